/* File: rtl/sosr_ctrl_top.sv */
// Data control register core: software sync, one-shot mode, soft reset.
// Assumes sync_out is wired back to sync_in on the board, and that
// conv_done_in is a one-cycle strobe from the filter on mclk_in.
//
// Notes on behaviour
// RULE_01: The data control register comes out of reset as 0x80.
// RULE_02: The host requests a sync by writing bit 7 low and later high.
// RULE_03: A sync is recognised only at the last clock edge of the low-to-high write.
// RULE_04: A recognised sync drives a master-clock-aligned pulse on sync_out.
// RULE_05: Each sync_in pulse resets the filters and holds data off until settled.
// RULE_06: In a daisy chain the host applies two successive sync pulses.
// RULE_07: With a shared clock and one data-ready pin the host applies two syncs.
// RULE_08: Bit 4 selects one-shot mode, one result per sync_in rising edge.
// RULE_09: The host soft resets by writing 0x03 then 0x02 to the reset field.
// RULE_10: The correct two-step sequence resets the core and all registers.
// RULE_11: The first command after a soft reset is answered with 0x0E00.
// RULE_12: With the retime bit set, sync_out comes from the alternate clock edge.
// RULE_13: A second code not directly after a first code does not reset.
`timescale 1ns/10ps
module sosr_ctrl_top
  import sosr_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_CYC_DEF
)(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  // Serial port
  input  wire logic sclk_in,
  input  wire logic csn_in,
  input  wire logic sdi_in,
  output logic      sdo_out,
  output logic      sdo_oe_out,
  // Synchronisation pins
  output logic      sync_out_out,
  input  wire logic sync_in_in,
  // Filter side
  input  wire logic conv_done_in,
  output logic      filter_reset_out,
  output logic      core_reset_out,
  output logic      data_ready_pin_out,
  output logic      one_shot_out
);
  sosr_frame_if bus ();

  logic [7:0]   gen_cfg_r, gen_cfg_nxt;
  logic [7:0]   dctrl_r, dctrl_nxt;
  sosr_rst_st_t rst_st_r, rst_st_nxt;
  logic         post_rst_r, post_rst_nxt;
  logic [15:0]  resp_r, resp_nxt;
  logic         core_rst_r, core_rst_nxt;
  logic [3:0]   sync_cnt_r, sync_cnt_nxt;
  logic         sync_pos_r, sync_pos_nxt;
  logic         sync_neg_r;
  logic [2:0]   sin_r, sin_nxt;
  logic [15:0]  settle_r, settle_nxt;
  logic         shot_pend_r, shot_pend_nxt;
  logic         data_ready_pin_r, data_ready_pin_nxt;
  logic         frst_r, frst_nxt;
  logic         wr, rd, wr_dctrl, first_cmd, second_cmd, soft_rst;
  logic         sync_req, sin_rise;
  logic [7:0]   wdata, rdata;

  // Read-back mux, shared by the answer path
  function automatic logic [7:0] reg_read(input logic [6:0] a,
                                          input logic [7:0] g,
                                          input logic [7:0] d);
    if (a == ADDR_GEN_CFG) begin
      reg_read = g;
    end else if (a == ADDR_DATA_CTRL) begin
      reg_read = d;
    end else begin
      reg_read = 8'h00;
    end
  endfunction : reg_read

  sosr_spi_rx u_rx (
    .mclk_in    (mclk_in),
    .resetn_in  (resetn_in),
    .sclk_in    (sclk_in),
    .csn_in     (csn_in),
    .sdi_in     (sdi_in),
    .sdo_out    (sdo_out),
    .sdo_oe_out (sdo_oe_out),
    .bus        (bus.rx)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  assign wdata      = bus.rx_word[7:0];
  assign wr         = bus.frame_done & ~bus.rx_word[BIT_RW];
  assign rd         = bus.frame_done & bus.rx_word[BIT_RW];
  assign wr_dctrl   = wr & (bus.rx_word[14:8] == ADDR_DATA_CTRL);
  assign first_cmd  = wr_dctrl & (wdata[1:0] == RST_CODE_FIRST);
  assign second_cmd = wr_dctrl & (wdata[1:0] == RST_CODE_SECOND);
  assign rdata      = reg_read(bus.rx_word[14:8], gen_cfg_r, dctrl_r);
  // RULE_10: reset only when armed by the frame just before
  assign soft_rst   = (rst_st_r == RST_ARMED) & second_cmd;
  // RULE_03: low-to-high change of the sync bit at frame completion
  assign sync_req   = wr_dctrl & wdata[BIT_SPI_SYNC] & ~dctrl_r[BIT_SPI_SYNC];

  ////////////////////////////////////////////////////////////////////////
  // Register file, soft reset sequencer and answer word
  always_comb begin
    gen_cfg_nxt  = gen_cfg_r;
    dctrl_nxt    = dctrl_r;
    rst_st_nxt   = rst_st_r;
    post_rst_nxt = post_rst_r;
    resp_nxt     = resp_r;
    core_rst_nxt = 1'b0;
    if (bus.frame_done) begin
      // RULE_13: any other frame disarms the sequence
      case (rst_st_r)
        RST_IDLE:  rst_st_nxt = first_cmd ? RST_ARMED : RST_IDLE;
        RST_ARMED: rst_st_nxt = first_cmd ? RST_ARMED : RST_IDLE;
        default:   rst_st_nxt = RST_IDLE;
      endcase
      // RULE_11: first command after soft reset answered with fixed word
      if (post_rst_r) begin
        resp_nxt     = SOFT_RST_RESP;
        post_rst_nxt = 1'b0;
      end else begin
        resp_nxt = rd ? {8'h00, rdata} : 16'h0000;
      end
      if (wr && bus.rx_word[14:8] == ADDR_GEN_CFG) begin
        gen_cfg_nxt = wdata;
      end
      if (wr_dctrl) begin
        dctrl_nxt = wdata;
      end
    end
    // RULE_10: digital core and registers back to defaults
    if (soft_rst) begin
      gen_cfg_nxt  = GEN_CFG_RST;
      dctrl_nxt    = DATA_CTRL_RST;
      rst_st_nxt   = RST_IDLE;
      post_rst_nxt = 1'b1;
      resp_nxt     = 16'h0000;
      core_rst_nxt = 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      gen_cfg_r  <= GEN_CFG_RST;
      // RULE_01: data control default
      dctrl_r    <= DATA_CTRL_RST;
      rst_st_r   <= RST_IDLE;
      post_rst_r <= 1'b0;
      resp_r     <= 16'h0000;
      core_rst_r <= 1'b0;
    end else begin
      gen_cfg_r  <= gen_cfg_nxt;
      dctrl_r    <= dctrl_nxt;
      rst_st_r   <= rst_st_nxt;
      post_rst_r <= post_rst_nxt;
      resp_r     <= resp_nxt;
      core_rst_r <= core_rst_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sync output, filter reset, settling and one-shot gating
  always_comb begin
    sync_cnt_nxt  = (sync_cnt_r != 4'h0) ? sync_cnt_r - 4'h1 : 4'h0;
    // RULE_04: fixed-width pulse on the master clock
    if (sync_req) begin
      sync_cnt_nxt = SYNC_PULSE_CYC;
    end
    sync_pos_nxt  = (sync_cnt_nxt != 4'h0);
    sin_nxt       = {sin_r[1:0], sync_in_in};
    sin_rise      = sin_r[1] & ~sin_r[2];
    frst_nxt      = sin_rise | core_rst_r;
    settle_nxt    = (settle_r != 16'h0000) ? settle_r - 16'h0001 : 16'h0000;
    shot_pend_nxt = shot_pend_r;
    data_ready_pin_nxt      = 1'b0;
    // RULE_05: output held off while the filter settles
    if (conv_done_in && settle_r == 16'h0000) begin
      // RULE_08: one-shot passes one result per sync edge
      if (!dctrl_r[BIT_ONE_SHOT] || shot_pend_r) begin
        data_ready_pin_nxt      = 1'b1;
        shot_pend_nxt = 1'b0;
      end
    end
    // RULE_05: sync edge restarts the filters; set wins over clear
    if (sin_rise || core_rst_r) begin
      settle_nxt    = SETTLE_CYC[15:0];
      shot_pend_nxt = sin_rise & dctrl_r[BIT_ONE_SHOT];
    end
  end

  // Register stage
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      sync_cnt_r  <= 4'h0;
      sync_pos_r  <= 1'b0;
      sin_r       <= 3'h0;
      frst_r      <= 1'b0;
      settle_r    <= 16'h0000;
      shot_pend_r <= 1'b0;
      data_ready_pin_r      <= 1'b0;
    end else begin
      sync_cnt_r  <= sync_cnt_nxt;
      sync_pos_r  <= sync_pos_nxt;
      sin_r       <= sin_nxt;
      frst_r      <= frst_nxt;
      settle_r    <= settle_nxt;
      shot_pend_r <= shot_pend_nxt;
      data_ready_pin_r      <= data_ready_pin_nxt;
    end
  end

  // RULE_12: half-cycle retimed copy of the sync pulse
  always_ff @(negedge mclk_in) begin
    if (!resetn_in) begin
      sync_neg_r <= 1'b0;
    end else begin
      sync_neg_r <= sync_pos_r;
    end
  end

  // Outputs
  assign sync_out_out       = gen_cfg_r[BIT_RETIME] ? sync_neg_r : sync_pos_r;
  assign bus.tx_word        = resp_r;
  assign filter_reset_out   = frst_r;
  assign core_reset_out     = core_rst_r;
  assign data_ready_pin_out = data_ready_pin_r;
  assign one_shot_out       = dctrl_r[BIT_ONE_SHOT];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  a_dctrl_reset_val: assert property ($rose(resetn_in) |-> dctrl_r == 8'h80) // RULE_01
    else $error("data control not at default after reset");
  a_sync_on_edge: assert property ($rose(sync_pos_r) |-> $past(sync_req)) // RULE_03
    else $error("sync pulse without low-to-high write");
  a_sync_pulse_len: assert property (sync_req |=> sync_pos_r [*4] ##1 !sync_pos_r) // RULE_04
    else $error("sync pulse width wrong");
  a_filter_reset: assert property (sin_rise |=> filter_reset_out ##1 settle_r != 16'h0000) // RULE_05
    else $error("sync edge did not restart filters");
  a_settle_gate: assert property (settle_r != 16'h0000 |=> !data_ready_pin_out) // RULE_05
    else $error("data ready during settling");
  a_one_shot_gate: assert property (dctrl_r[4] && !shot_pend_r |=> !data_ready_pin_out) // RULE_08
    else $error("one-shot result without sync edge");
  a_soft_reset: assert property (soft_rst |=> core_reset_out && dctrl_r == 8'h80 && post_rst_r) // RULE_10
    else $error("soft reset sequence ignored");
  a_reset_answer: assert property (post_rst_r && bus.frame_done |=> resp_r == 16'h0E00) // RULE_11
    else $error("wrong answer after soft reset");
  a_retime_sel: assert property (gen_cfg_r[5] |-> sync_out_out == sync_neg_r) // RULE_12
    else $error("retimed sync not selected");
  a_seq_abort: assert property (second_cmd && $past(rst_st_r) != RST_ARMED && rst_st_r == RST_IDLE
                                |=> !core_reset_out) // RULE_13
    else $error("reset without first code");

  c_soft_reset: cover property (soft_rst);
  c_sync_pulse: cover property (sync_req ##[1:8] sync_out_out);
  c_one_shot:   cover property (dctrl_r[4] && sin_rise ##[1:200] data_ready_pin_out);
endmodule : sosr_ctrl_top

/* File: rtl/sosr_pkg.sv */
// Constants and types of the sync / one-shot / soft-reset control block.
// Assumes a 16-bit serial frame: R/W flag, 7-bit address, 8-bit data.
package sosr_pkg;
  // Register offsets
  localparam logic [6:0]  ADDR_GEN_CFG    = 7'h05;
  localparam logic [6:0]  ADDR_DATA_CTRL  = 7'h06;
  // Reset values
  localparam logic [7:0]  GEN_CFG_RST     = 8'h08;
  localparam logic [7:0]  DATA_CTRL_RST   = 8'h80;
  // Field positions
  localparam int          BIT_SPI_SYNC    = 7;
  localparam int          BIT_ONE_SHOT    = 4;
  localparam int          BIT_RETIME      = 5;
  localparam int          BIT_RW          = 15;
  // Soft reset codes and answer
  localparam logic [1:0]  RST_CODE_FIRST  = 2'b11;
  localparam logic [1:0]  RST_CODE_SECOND = 2'b10;
  localparam logic [15:0] SOFT_RST_RESP   = 16'h0E00;
  // Frame and timing counts
  localparam int          FRAME_BITS      = 16;
  localparam logic [3:0]  SYNC_PULSE_CYC  = 4'h4;
  localparam int          SETTLE_CYC_DEF  = 64;
  // Soft reset sequence state
  typedef enum logic {
    RST_IDLE  = 1'b0,
    RST_ARMED = 1'b1
  } sosr_rst_st_t;
endpackage : sosr_pkg

/* File: rtl/sosr_frame_if.sv */
// Frame carrier between the serial receiver and the register core.
// Assumes one clock domain; frame_done is a one-cycle pulse.
`timescale 1ns/10ps
interface sosr_frame_if;
  logic        frame_done;
  logic [15:0] rx_word;
  logic [15:0] tx_word;
  modport rx   (output frame_done, output rx_word, input tx_word);
  modport core (input frame_done, input rx_word, output tx_word);
endinterface : sosr_frame_if

/* File: rtl/sosr_spi_rx.sv */
// Serial port slave: oversamples the serial pins on the master clock.
// Assumes the serial clock runs well below a quarter of the master clock.
`timescale 1ns/10ps
module sosr_spi_rx
  import sosr_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  // Serial pins
  input  wire logic sclk_in,
  input  wire logic csn_in,
  input  wire logic sdi_in,
  output logic      sdo_out,
  output logic      sdo_oe_out,
  // Frame carrier
  sosr_frame_if.rx  bus
);
  logic [2:0]  sclk_r, sclk_nxt;
  logic [1:0]  csn_r, csn_nxt;
  logic [1:0]  sdi_r, sdi_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [15:0] tx_r, tx_nxt;
  logic [15:0] rx_r, rx_nxt;
  logic        done_r, done_nxt;
  logic        sdo_r, sdo_nxt;
  logic        csn_d_r, csn_d_nxt;
  logic        rise, fall, act;

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; edges are taken from the second and third stage
  always_comb begin
    sclk_nxt  = {sclk_r[1:0], sclk_in};
    csn_nxt   = {csn_r[0], csn_in};
    sdi_nxt   = {sdi_r[0], sdi_in};
    rise      = sclk_r[1] & ~sclk_r[2];
    fall      = ~sclk_r[1] & sclk_r[2];
    act       = ~csn_r[1];
    csn_d_nxt = csn_r[1];
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    tx_nxt    = tx_r;
    rx_nxt    = rx_r;
    sdo_nxt   = sdo_r;
    done_nxt  = 1'b0;
    if (!act) begin
      cnt_nxt = 4'h0;
    end else if (csn_d_r) begin
      // Frame start: latch the pending answer, present its first bit
      tx_nxt  = bus.tx_word;
      sdo_nxt = bus.tx_word[FRAME_BITS-1];
    end else begin
      if (rise) begin
        sh_nxt  = {sh_r[14:0], sdi_r[1]};
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == 4'hF) begin
          // Final rising edge of the frame completes the command
          rx_nxt   = {sh_r[14:0], sdi_r[1]};
          done_nxt = 1'b1;
        end
      end
      if (fall) begin
        tx_nxt  = {tx_r[14:0], 1'b0};
        sdo_nxt = tx_r[FRAME_BITS-2];
      end
    end
  end

  // Register stage
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      sclk_r  <= 3'h0;
      csn_r   <= 2'h3;
      sdi_r   <= 2'h0;
      cnt_r   <= 4'h0;
      sh_r    <= 16'h0000;
      tx_r    <= 16'h0000;
      rx_r    <= 16'h0000;
      done_r  <= 1'b0;
      sdo_r   <= 1'b0;
      csn_d_r <= 1'b1;
    end else begin
      sclk_r  <= sclk_nxt;
      csn_r   <= csn_nxt;
      sdi_r   <= sdi_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      tx_r    <= tx_nxt;
      rx_r    <= rx_nxt;
      done_r  <= done_nxt;
      sdo_r   <= sdo_nxt;
      csn_d_r <= csn_d_nxt;
    end
  end

  assign bus.frame_done = done_r;
  assign bus.rx_word    = rx_r;
  assign sdo_out        = sdo_r;
  assign sdo_oe_out     = ~csn_r[1];
endmodule : sosr_spi_rx

/* File: bench/sosr_spi_host.sv */
// SPI host model that drives register frames into the control block.
// Assumes sclk well below mclk/4; frame timing is counted in mclk cycles.
`timescale 1ns/10ps
module sosr_spi_host #(
  parameter int HALF_CYC = 6
)(
  // Clock
  input  wire logic mclk_in,
  // Serial pins
  output logic      sclk_out,
  output logic      csn_out,
  output logic      sdi_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in
);
  logic sdi_last;

  // Idle pins: clock still, chip select high
  initial begin
    sclk_out = 1'b0;
    csn_out  = 1'b1;
    sdi_out  = 1'b0;
    sdi_last = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // One frame, MSB first; nbits below 16 aborts by lifting csn early
  task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge mclk_in) #1 csn_out = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      sdi_out  = tx[i];
      sdi_last = tx[i];
      repeat (HALF_CYC) @(posedge mclk_in);
      // Undriven sdo must never pass for data
      #1 rx[i] = sdo_oe_in ? sdo_in : 1'bx;
      sclk_out = 1'b1;
      repeat (HALF_CYC) @(posedge mclk_in);
      #1 sclk_out = 1'b0;
    end
    repeat (HALF_CYC) @(posedge mclk_in);
    #1 csn_out = 1'b1;
    // Released line shows the inverse, so a stale bit cannot hide a fault
    sdi_out = ~sdi_last;
    repeat (8) @(posedge mclk_in);
  endtask : frame
endmodule : sosr_spi_host

/* File: bench/sync_oneshot_softreset_ctrl_tb.sv */
// Self-checking bench for the sync / one-shot / soft-reset control block.
// Assumes the host model above; sync_out is looped back to sync_in here.
`timescale 1ns/10ps
module sync_oneshot_softreset_ctrl_tb;
  import sosr_pkg::*;
  localparam int SETTLE = 8;
  logic        mclk_in;
  logic        resetn_in;
  logic        sclk, csn, sdi, sdo, sdo_oe;
  logic        sync_out, sync_ext, conv_done;
  logic        frst, crst, data_ready_pin, one_shot, edge_hi;
  logic [15:0] ans;
  int          n_fail, n_tests, cyc, n_sync, n_frst, n_crst, n_data_ready_pin;

  // Board loop from sync_out to sync_in, plus an external pulse source
  sosr_ctrl_top #(.SETTLE_CYC(SETTLE)) u_sosr_ctrl_top (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .sclk_in(sclk), .csn_in(csn),
    .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .sync_out_out(sync_out),
    .sync_in_in(sync_out | sync_ext), .conv_done_in(conv_done),
    .filter_reset_out(frst), .core_reset_out(crst),
    .data_ready_pin_out(data_ready_pin), .one_shot_out(one_shot));
  sosr_spi_host u_sosr_spi_host (
    .mclk_in(mclk_in), .sclk_out(sclk), .csn_out(csn), .sdi_out(sdi),
    .sdo_in(sdo), .sdo_oe_in(sdo_oe));

  //////////////////////////////////////////////////////////////////////
  // Clock, pulse counters and hang guard
  initial mclk_in = 1'b0;
  always #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    if (sync_out === 1'b1) n_sync++;
    if (frst === 1'b1) n_frst++;
    if (crst === 1'b1) n_crst++;
    if (data_ready_pin === 1'b1) n_data_ready_pin++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  // Clock level at the sync rise tells which edge launched it
  always @(posedge sync_out) edge_hi = mclk_in;

  //////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic clr();
    #1 n_sync = 0;
    n_frst = 0;
    n_crst = 0;
    n_data_ready_pin = 0;
  endtask : clr

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_sosr_spi_host.frame({1'b0, a, d}, 16, ans);
  endtask : wr

  task automatic rd(input logic [6:0] a);
    u_sosr_spi_host.frame({1'b1, a, 8'h00}, 16, ans);
  endtask : rd

  task automatic strobe(input int which);
    @(posedge mclk_in) #1;
    if (which == 0) conv_done = 1'b1;
    else sync_ext = 1'b1;
    @(posedge mclk_in) #1;
    conv_done = 1'b0;
    sync_ext  = 1'b0;
  endtask : strobe

  //////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd(ADDR_DATA_CTRL);
    rd(ADDR_GEN_CFG);
    check(ans, {8'h00, DATA_CTRL_RST}, "data control reset");
    rd(7'h10);
    check(ans, {8'h00, GEN_CFG_RST}, "config reset");
    rd(ADDR_DATA_CTRL);
    check(ans, 16'h0000, "unmapped read");
    check(16'(one_shot), 16'h0000, "one shot off");
    $display("test reset done");
  endtask : t_reset

  task automatic t_sync(input logic [7:0] cfg);
    wr(ADDR_GEN_CFG, cfg);
    clr();
    wr(ADDR_DATA_CTRL, 8'h00);
    u_sosr_spi_host.frame({1'b0, ADDR_DATA_CTRL, 8'h80}, 15, ans);
    check(16'(n_sync), 16'h0000, "sync before final edge");
    wr(ADDR_DATA_CTRL, 8'h80);
    repeat (10) @(posedge mclk_in);
    check(16'(n_sync), 16'(SYNC_PULSE_CYC), "sync width");
    check(16'(edge_hi), 16'(!cfg[BIT_RETIME]), "sync launch edge");
    check(16'(n_frst), 16'h0001, "looped sync resets filter");
    clr();
    wr(ADDR_DATA_CTRL, 8'h80);
    repeat (10) @(posedge mclk_in);
    check(16'(n_sync), 16'h0000, "no sync without low write");
    $display("test sync done");
  endtask : t_sync

  task automatic t_conv(input logic os);
    wr(ADDR_DATA_CTRL, {3'b100, os, 4'h0});
    check(16'(one_shot), 16'(os), "one shot level");
    clr();
    strobe(1);
    repeat (5) @(posedge mclk_in);
    strobe(0);
    check(16'(n_data_ready_pin), 16'h0000, "held while settling");
    repeat (SETTLE) @(posedge mclk_in);
    strobe(0);
    strobe(0);
    repeat (3) @(posedge mclk_in);
    check(16'(n_data_ready_pin), os ? 16'h0001 : 16'h0002, "results released");
    check(16'(n_frst), 16'h0001, "filter reset per sync");
    $display("test conversion done");
  endtask : t_conv

  task automatic t_srst();
    wr(ADDR_GEN_CFG, 8'h28);
    clr();
    wr(ADDR_DATA_CTRL, 8'h93);
    wr(ADDR_DATA_CTRL, 8'h82);
    check(16'(n_crst), 16'h0001, "core reset pulse");
    check(16'(one_shot), 16'h0000, "one shot cleared");
    rd(ADDR_GEN_CFG);
    check(ans, 16'h0000, "answer to reset frame");
    rd(ADDR_DATA_CTRL);
    check(ans, SOFT_RST_RESP, "first answer after reset");
    rd(ADDR_GEN_CFG);
    check(ans, {8'h00, DATA_CTRL_RST}, "data control restored");
    rd(ADDR_DATA_CTRL);
    check(ans, {8'h00, GEN_CFG_RST}, "config restored");
    $display("test soft reset done");
  endtask : t_srst

  task automatic t_bad();
    clr();
    wr(ADDR_DATA_CTRL, 8'h82);
    wr(ADDR_DATA_CTRL, 8'h83);
    rd(ADDR_GEN_CFG);
    wr(ADDR_DATA_CTRL, 8'h82);
    rd(ADDR_DATA_CTRL);
    rd(ADDR_GEN_CFG);
    check(16'(n_crst), 16'h0000, "no reset out of order");
    check(ans, 16'h0082, "field kept");
    $display("test bad sequence done");
  endtask : t_bad

  //////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Main sequence; two successive syncs, as a multi-device host would
  initial begin
    resetn_in = 1'b0;
    sync_ext  = 1'b0;
    conv_done = 1'b0;
    repeat (8) @(posedge mclk_in);
    #1 resetn_in = 1'b1;
    t_reset();
    t_sync(8'h08);
    t_sync(8'h28);
    t_conv(1'b1);
    t_conv(1'b0);
    t_srst();
    t_bad();
    conclude();
  end
endmodule : sync_oneshot_softreset_ctrl_tb
